// ### t16_pin_sync.v
// two-stage synchroniser for an outside pin with edge detection
`timescale 1ns/100ps
module t16_pin_sync (
    input wire mclk,
    input wire sys_rst,
    input wire pin,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_r;
    reg sync_r;
    reg last_r;

    // first stage feeds only the second; edges come from later stages
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~last_r;
    assign fall = ~sync_r & last_r;
endmodule

// ### t16_pins.sv
// pin-side model: event input, watch timer pulses and a slow subclock
`timescale 1ns/100ps
module t16_pins #(
    parameter integer WATCH_DIV = 5,
    parameter integer SUB_HALF = 7
) (
    input wire mclk,
    input wire sys_rst,
    output logic external_event_input,
    output logic subsystem_clock,
    output logic watch_timer_output
);
    integer wcnt;
    integer scnt;
    initial external_event_input = 1'b0;
    // both sources run free, like the real oscillator and watch timer
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wcnt <= 0;
            scnt <= 0;
            watch_timer_output <= 1'b0;
            subsystem_clock <= 1'b0;
        end else begin
            wcnt <= (wcnt == WATCH_DIV - 1) ? 0 : wcnt + 1;
            watch_timer_output <= (wcnt == WATCH_DIV - 1);
            scnt <= (scnt == SUB_HALF - 1) ? 0 : scnt + 1;
            if (scnt == SUB_HALF - 1) subsystem_clock <= ~subsystem_clock;
        end
    end
    // one pulse, wide enough to pass the two-flop synchroniser
    task automatic ev_pulse;
        @(posedge mclk);
        external_event_input <= 1'b1;
        repeat (5) @(posedge mclk);
        external_event_input <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask
endmodule

// ### t16_regs.vh
// register map, field positions, reset values and codes of the 16-bit timer
`ifndef T16_REGS_VH
`define T16_REGS_VH

// byte addresses on the register port
`define T16_ADDR_CCS 16'hFF40
`define T16_ADDR_TMC 16'hFF48
`define T16_ADDR_CCC 16'hFF4A
`define T16_ADDR_ESEL 16'hFF4C
`define T16_ADDR_TOC 16'hFF4E
`define T16_ADDR_CMP0_L 16'hFF12
`define T16_ADDR_CMP0_H 16'hFF13
`define T16_ADDR_CMP1_L 16'hFF14
`define T16_ADDR_CMP1_H 16'hFF15
`define T16_ADDR_CNT_L 16'hFF16
`define T16_ADDR_CNT_H 16'hFF17

// reset values
`define T16_RST_CCS 8'h00
`define T16_RST_MODE 3'h0
`define T16_RST_CCC 2'h0
`define T16_RST_ESEL 2'h0
`define T16_RST_TOC 2'h0
`define T16_RST_CMP 16'h0000
`define T16_RST_BYTE 8'h00

// count_clock_select fields
`define T16_CLOCK_OUTPUT_ENABLE_BIT 7
`define T16_CSEL_MSB 6
`define T16_CSEL_LSB 4
`define T16_OSEL_MSB 3
`define T16_OSEL_LSB 0

// timer_mode_control fields
`define T16_MODE_MSB 3
`define T16_MODE_LSB 1
`define T16_OVF_BIT 0

// capture_compare_control fields
`define T16_CAP0_BIT 0
`define T16_CAP1_BIT 1

// timer_output_control fields
`define T16_TOC_EN_BIT 0
`define T16_TOC_INV_BIT 1
`define T16_TOC_SET_BIT 2
`define T16_TOC_CLR_BIT 3
`define T16_TOC_TRIG_BIT 4

// count clock codes
`define T16_CSEL_EXT 3'h0
`define T16_CSEL_MAIN 3'h2
`define T16_CSEL_DIV2 3'h3
`define T16_CSEL_DIV4 3'h4
`define T16_CSEL_WATCH 3'h7

// clock output codes
`define T16_OSEL_SUB 4'h0
`define T16_OSEL_DIV1 4'h5
`define T16_OSEL_DIV128 4'hC

// operating modes
`define T16_MODE_STOP 3'h0
`define T16_MODE_PWM 3'h1
`define T16_CLR_EDGE 2'h2
`define T16_CLR_CMP 2'h3

// valid edge codes
`define T16_EDGE_FALL 2'h0
`define T16_EDGE_RISE 2'h1
`define T16_EDGE_BOTH 2'h2

`define T16_CNT_MAX 16'hFFFF
`define T16_DIV_W 8

`endif

// ### t16_timer.v
// 16-bit timer/event counter with programmable clock output
`timescale 1ns/100ps
`include "t16_regs.vh"
module t16_timer (
    input wire mclk,
    input wire sys_rst,
    input wire [15:0] addr,
    input wire [7:0] wr_data,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rd_data,
    input wire external_event_input,
    input wire subsystem_clock,
    input wire watch_timer_output,
    output reg timer_output_pin,
    output reg clock_output_pin,
    output reg match0_req,
    output reg match1_req
);
    // software registers, counter state and combinational helpers
    reg [7:0] count_clock_select_r;
    reg [2:0] mode_field_r;
    reg overflow_flag_r;
    reg [1:0] capture_compare_control_r;
    reg [1:0] edge_select_r;
    reg [1:0] timer_output_control_r;
    reg [15:0] first_compare_r;
    reg [15:0] second_compare_r;
    reg [15:0] sixteen_bit_counter_r;
    reg [15:0] counter_nxt;
    reg [`T16_DIV_W-1:0] div_r;
    reg out_latch_r;
    reg count_tick;
    reg valid_edge;
    reg clk_sel;
    reg [7:0] read_nxt;

    // synchronised pin levels and edges
    wire ev_level;
    wire ev_rise;
    wire ev_fall;
    wire sub_level;

    // merge a written byte into one half of a 16-bit register
    function [15:0] put_byte;
        input [15:0] old;
        input [7:0] data;
        input high;
        begin
            if (high) begin
                put_byte = {data, old[7:0]};
            end else begin
                put_byte = {old[15:8], data};
            end
        end
    endfunction

    // true when a strobe hits one address
    function hit;
        input stb;
        input [15:0] a;
        input [15:0] target;
        begin
            hit = stb & (a == target);
        end
    endfunction

    // external event pin and subsystem clock come from outside mclk
    t16_pin_sync u_event_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(external_event_input),
        .level(ev_level),
        .rise(ev_rise),
        .fall(ev_fall)
    );

    t16_pin_sync u_sub_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(subsystem_clock),
        .level(sub_level),
        .rise(),
        .fall()
    );

    // control fields; a capture bit turns its compare register off
    wire [2:0] csel = count_clock_select_r[`T16_CSEL_MSB:`T16_CSEL_LSB];
    wire [3:0] osel = count_clock_select_r[`T16_OSEL_MSB:`T16_OSEL_LSB];
    wire [3:0] oidx = osel - `T16_OSEL_DIV1;
    wire running = (mode_field_r != `T16_MODE_STOP);
    wire pwm_mode = (mode_field_r == `T16_MODE_PWM);
    wire [1:0] clr_kind = mode_field_r[2:1];
    wire cmp0_on = ~capture_compare_control_r[`T16_CAP0_BIT];
    wire cmp1_on = ~capture_compare_control_r[`T16_CAP1_BIT];
    wire out_en = timer_output_control_r[`T16_TOC_EN_BIT];
    wire out_inv = timer_output_control_r[`T16_TOC_INV_BIT];

    // write decodes, one per writable byte address
    wire wr_ccs = hit(wr_stb, addr, `T16_ADDR_CCS);
    wire wr_tmc = hit(wr_stb, addr, `T16_ADDR_TMC);
    wire wr_ccc = hit(wr_stb, addr, `T16_ADDR_CCC);
    wire wr_esel = hit(wr_stb, addr, `T16_ADDR_ESEL);
    wire wr_toc = hit(wr_stb, addr, `T16_ADDR_TOC);
    wire wr_c0l = hit(wr_stb, addr, `T16_ADDR_CMP0_L);
    wire wr_c0h = hit(wr_stb, addr, `T16_ADDR_CMP0_H);
    wire wr_c1l = hit(wr_stb, addr, `T16_ADDR_CMP1_L);
    wire wr_c1h = hit(wr_stb, addr, `T16_ADDR_CMP1_H);

    // valid edge of the event pin, as chosen by the edge select register
    always @* begin
        case (edge_select_r)
            `T16_EDGE_FALL: valid_edge = ev_fall;
            `T16_EDGE_RISE: valid_edge = ev_rise;
            `T16_EDGE_BOTH: valid_edge = ev_rise | ev_fall;
            default: valid_edge = 1'b0;
        endcase
    end

    // count event; prohibited codes simply never count
    always @* begin
        case (csel)
            `T16_CSEL_EXT: count_tick = valid_edge;
            `T16_CSEL_MAIN: count_tick = 1'b1;
            `T16_CSEL_DIV2: count_tick = div_r[0];
            `T16_CSEL_DIV4: count_tick = &div_r[1:0];
            `T16_CSEL_WATCH: count_tick = watch_timer_output;
            default: count_tick = 1'b0;
        endcase
    end

    // matches are only seen on a count event so each lasts one cycle
    wire match0 = running & count_tick & cmp0_on &
        (sixteen_bit_counter_r == first_compare_r);
    wire match1 = running & count_tick & cmp1_on &
        (sixteen_bit_counter_r == second_compare_r);
    // clear sources; an edge clear beats counting in the same cycle
    wire clr_on_edge = running & (clr_kind == `T16_CLR_EDGE) & valid_edge;
    wire clr_on_cmp = (clr_kind == `T16_CLR_CMP) & match0;
    wire overflow = running & count_tick &
        (sixteen_bit_counter_r == `T16_CNT_MAX);
    wire out_edge_ev = mode_field_r[0] & ~pwm_mode & running & valid_edge;

    // next counter value; clearing on the match gives compare+1 counts
    always @* begin
        counter_nxt = sixteen_bit_counter_r;
        if (!running) begin
            counter_nxt = 16'h0000;
        end else if (clr_on_edge) begin
            counter_nxt = 16'h0000;
        end else if (count_tick) begin
            if (clr_on_cmp) begin
                counter_nxt = 16'h0000;
            end else begin
                counter_nxt = sixteen_bit_counter_r + 16'h0001;
            end
        end
    end

    // counter and prescaler; prescaler runs free so rates stay exact
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sixteen_bit_counter_r <= `T16_RST_CMP;
            div_r <= {`T16_DIV_W{1'b0}};
        end else begin
            sixteen_bit_counter_r <= counter_nxt;
            div_r <= div_r + {{(`T16_DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // control registers; mode change takes effect on the next cycle
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count_clock_select_r <= `T16_RST_CCS;
            mode_field_r <= `T16_RST_MODE;
            capture_compare_control_r <= `T16_RST_CCC;
            edge_select_r <= `T16_RST_ESEL;
            timer_output_control_r <= `T16_RST_TOC;
        end else begin
            if (wr_ccs) begin
                count_clock_select_r <= wr_data;
            end
            if (wr_tmc) begin
                mode_field_r <= wr_data[`T16_MODE_MSB:`T16_MODE_LSB];
            end
            if (wr_ccc) begin
                capture_compare_control_r <= wr_data[1:0];
            end
            if (wr_esel) begin
                edge_select_r <= wr_data[1:0];
            end
            if (wr_toc) begin
                timer_output_control_r <= wr_data[1:0];
            end
        end
    end

    // overflow flag: hardware set wins over a software clear
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            overflow_flag_r <= 1'b0;
        end else if (overflow) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_tmc) begin
            overflow_flag_r <= wr_data[`T16_OVF_BIT];
        end
    end

    // compare registers; a capture on the same cycle beats a write
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            first_compare_r <= `T16_RST_CMP;
            second_compare_r <= `T16_RST_CMP;
        end else begin
            if (running & valid_edge & ~cmp0_on) begin
                first_compare_r <= sixteen_bit_counter_r;
            end else if (wr_c0l | wr_c0h) begin
                first_compare_r <= put_byte(first_compare_r, wr_data, wr_c0h);
            end
            if (running & valid_edge & ~cmp1_on) begin
                second_compare_r <= sixteen_bit_counter_r;
            end else if (wr_c1l | wr_c1h) begin
                second_compare_r <= put_byte(second_compare_r, wr_data, wr_c1h);
            end
        end
    end

    // output latch: software set/reset first, then trigger, then events
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_latch_r <= 1'b0;
        end else if (wr_toc & wr_data[`T16_TOC_SET_BIT]) begin
            out_latch_r <= 1'b1;
        end else if (wr_toc & wr_data[`T16_TOC_CLR_BIT]) begin
            out_latch_r <= 1'b0;
        end else if (wr_toc & wr_data[`T16_TOC_TRIG_BIT]) begin
            out_latch_r <= ~out_latch_r;
        end else if (running & ~pwm_mode & (match0 | match1 | out_edge_ev)) begin
            out_latch_r <= ~out_latch_r;
        end
    end

    // timer output pin; stop mode freezes it at its last level
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_output_pin <= 1'b0;
        end else if (!running) begin
            timer_output_pin <= timer_output_pin;
        end else if (pwm_mode) begin
            timer_output_pin <= out_en &
                ((sixteen_bit_counter_r < first_compare_r) ^ out_inv);
        end else begin
            timer_output_pin <= out_en & (out_latch_r ^ out_inv);
        end
    end

    // match requests: one-cycle pulses, none after the first stopped cycle
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            match0_req <= 1'b0;
            match1_req <= 1'b0;
        end else begin
            match0_req <= match0;
            match1_req <= match1;
        end
    end

    // clock output source; a flop output cannot reach mclk itself
    always @* begin
        if (osel == `T16_OSEL_SUB) begin
            clk_sel = sub_level;
        end else if (osel >= `T16_OSEL_DIV1 && osel <= `T16_OSEL_DIV128) begin
            clk_sel = div_r[oidx[2:0]];
        end else begin
            clk_sel = 1'b0;
        end
    end

    // clock output pin; gating after the mux keeps the enable glitch free
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_output_pin <= 1'b0;
        end else begin
            clock_output_pin <= count_clock_select_r[`T16_CLOCK_OUTPUT_ENABLE_BIT] &
                clk_sel;
        end
    end

    // read mux; unmapped addresses and write-only bits read zero
    always @* begin
        case (addr)
            `T16_ADDR_CCS: read_nxt = count_clock_select_r;
            `T16_ADDR_TMC: read_nxt = {4'h0, mode_field_r,
                overflow_flag_r};
            `T16_ADDR_CCC: read_nxt = {6'h00, capture_compare_control_r};
            `T16_ADDR_ESEL: read_nxt = {6'h00, edge_select_r};
            `T16_ADDR_TOC: read_nxt = {6'h00,
                timer_output_control_r};
            `T16_ADDR_CMP0_L: read_nxt = first_compare_r[7:0];
            `T16_ADDR_CMP0_H: read_nxt = first_compare_r[15:8];
            `T16_ADDR_CMP1_L: read_nxt = second_compare_r[7:0];
            `T16_ADDR_CMP1_H: read_nxt = second_compare_r[15:8];
            `T16_ADDR_CNT_L: read_nxt = sixteen_bit_counter_r[7:0];
            `T16_ADDR_CNT_H: read_nxt = sixteen_bit_counter_r[15:8];
            default: read_nxt = `T16_RST_BYTE;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= `T16_RST_BYTE;
        end else if (rd_stb) begin
            rd_data <= read_nxt;
        end else begin
            rd_data <= `T16_RST_BYTE;
        end
    end
endmodule

// ### t16_timer_asserts.sv
// port checker for the 16-bit timer, bound to its top module
`timescale 1ns/100ps
`include "t16_regs.vh"
module t16_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic external_event_input,
    input wire logic timer_output_pin,
    input wire logic clock_output_pin,
    input wire logic match0_req,
    input wire logic match1_req
);
    logic [2:0] mode_r, csel_r, quiet_r, cfg_r;
    logic [3:0] osel_r;
    logic [1:0] esel_r;
    logic clock_output_enable_r, toe_r, arm_r;
    logic [15:0] cmp0_r, gap_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // shadow of software writes; ages let outputs settle before judging
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {mode_r, csel_r, osel_r, esel_r, clock_output_enable_r, toe_r} <= 14'h0000;
            {quiet_r, cfg_r, arm_r} <= 7'h00;
            {cmp0_r, gap_r} <= 32'h0000_0000;
        end else begin
            gap_r <= match0_req ? 16'h0000 : gap_r + 16'h0001;
            arm_r <= !wr_stb && (match0_req || arm_r);
            quiet_r <= (wr_stb || mode_r != 3'h0) ? 3'h0
                : quiet_r + {2'h0, quiet_r != 3'h7};
            cfg_r <= (wr_stb && addr == `T16_ADDR_CCS) ? 3'h0
                : cfg_r + {2'h0, cfg_r != 3'h7};
            if (wr_stb) begin
                case (addr)
                    `T16_ADDR_TMC: mode_r <= wr_data[3:1];
                    `T16_ADDR_CCS: {clock_output_enable_r, csel_r, osel_r} <= wr_data;
                    `T16_ADDR_ESEL: esel_r <= wr_data[1:0];
                    `T16_ADDR_TOC: toe_r <= wr_data[0];
                    `T16_ADDR_CMP0_L: cmp0_r[7:0] <= wr_data;
                    `T16_ADDR_CMP0_H: cmp0_r[15:8] <= wr_data;
                    default: ;
                endcase
            end
        end
    end
    a_read_slot:
        assert property (!$past(rd_stb) |-> rd_data == 8'h00)
        else $error("read data outside its slot");
    a_stop_noreq:
        assert property (mode_r == 3'h0 && $past(mode_r) == 3'h0
            |-> !match0_req && !match1_req)
        else $error("request while stopped");
    a_stop_frozen:
        assert property (quiet_r >= 3'h4 |-> $stable(timer_output_pin))
        else $error("output pin moved while stopped");
    a_clkout_off:
        assert property (!clock_output_enable_r && !$past(clock_output_enable_r) && !$past(clock_output_enable_r, 2)
            |-> !clock_output_pin)
        else $error("clock output active while disabled");
    a_clkout_div2:
        assert property (cfg_r >= 3'h4 && clock_output_enable_r && osel_r == 4'h5
            |-> clock_output_pin != $past(clock_output_pin))
        else $error("clock output not toggling each cycle");
    a_clkout_div4:
        assert property (cfg_r >= 3'h4 && clock_output_enable_r && osel_r == 4'h6
            && $rose(clock_output_pin)
            |=> clock_output_pin ##1 !clock_output_pin)
        else $error("clock output high time wrong");
    a_cmp_period:
        assert property (arm_r && match0_req && csel_r == 3'h2
            && mode_r[2:1] == 2'h3 |-> gap_r == cmp0_r)
        else $error("compare interval wrong");
    a_edge_toggle:
        assert property ($rose(external_event_input) && mode_r == 3'h5
            && toe_r && esel_r == 2'h1 |-> ##[2:8] $changed(timer_output_pin))
        else $error("output pin ignored valid edge");
endmodule
bind t16_timer t16_chk i_t16_chk (.mclk(mclk), .sys_rst(sys_rst),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .external_event_input(external_event_input),
    .timer_output_pin(timer_output_pin),
    .clock_output_pin(clock_output_pin), .match0_req(match0_req),
    .match1_req(match1_req));

// ### testbench.sv
// self-checking testbench for the 16-bit timer block
`timescale 1ns/100ps
`include "t16_regs.vh"
module testbench;
    localparam integer WDIV = 5;
    logic mclk, sys_rst, wr_stb, rd_stb, p;
    logic [15:0] addr, v;
    logic [7:0] wr_data;
    wire [7:0] rd_data;
    wire ev, sub, watch, tout, cout, m0, m1;
    integer fails, comparisons, n, i;
    logic [2:0] csel_tab [4] = '{3'h2, 3'h3, 3'h4, 3'h7};
    integer fac_tab [4] = '{1, 2, 4, WDIV};
    t16_timer i_t16_timer (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .external_event_input(ev),
        .subsystem_clock(sub), .watch_timer_output(watch),
        .timer_output_pin(tout), .clock_output_pin(cout),
        .match0_req(m0), .match1_req(m1));
    t16_pins #(.WATCH_DIV(WDIV)) i_t16_pins (.mclk(mclk), .sys_rst(sys_rst),
        .external_event_input(ev), .subsystem_clock(sub),
        .watch_timer_output(watch));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] val);
        @(posedge mclk);
        addr <= a;
        wr_data <= val;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    // low byte first; the halves are separate registers
    task automatic wr16(input logic [15:0] a, input logic [15:0] val);
        wr(a, val[7:0]);
        wr(a + 16'h0001, val[15:8]);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] val);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        val = {8'h00, rd_data};
    endtask
    task automatic rd16(input logic [15:0] a, output logic [15:0] val);
        logic [15:0] lo, hi;
        rd(a, lo);
        rd(a + 16'h0001, hi);
        val = {hi[7:0], lo[7:0]};
    endtask
    task automatic wait_req(input logic sel, output integer cnt);
        cnt = 0;
        do begin
            @(posedge mclk);
            cnt++;
        end while ((sel ? m1 : m0) !== 1'b1 && cnt < 4000);
    endtask
    task automatic toggles(output integer cnt);
        logic last;
        repeat (8) @(posedge mclk);
        last = cout;
        cnt = 0;
        repeat (16) begin
            @(posedge mclk);
            if (cout !== last) cnt++;
            last = cout;
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // a hang past the expected run length ends the test as failed
    initial begin
        repeat (90000) @(posedge mclk);
        fails++;
        $display("wrong value watchdog expected finish seen timeout");
        end_sim;
    end
    initial begin
        {fails, comparisons} = 0;
        {sys_rst, wr_stb, rd_stb} = 3'h4;
        {addr, wr_data} = 24'h000000;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`T16_ADDR_CCS, v);
        chk("select reset", v, 16'h0000);
        rd(`T16_ADDR_TMC, v);
        chk("mode reset", v, 16'h0000);
        rd(16'hFF00, v);
        chk("unmapped read", v, 16'h0000);
        wr(`T16_ADDR_CCS, 8'h25);
        rd(`T16_ADDR_CCS, v);
        chk("select readback", v, 16'h0025);
        wr(`T16_ADDR_TMC, 8'hF0);
        rd(`T16_ADDR_TMC, v);
        chk("mode upper bits", v, 16'h0000);
        wr(`T16_ADDR_TOC, 8'h1D);
        rd(`T16_ADDR_TOC, v);
        chk("output control", {11'h000, v[4:0]}, 16'h0001);
        $display("test registers done");
        wr16(`T16_ADDR_CMP0_L, 16'h0003);
        wr16(`T16_ADDR_CMP1_L, 16'h0002);
        for (i = 0; i < 4; i++) begin
            wr(`T16_ADDR_TMC, 8'h00);
            wr(`T16_ADDR_CCS, {1'b0, csel_tab[i], 4'h0});
            wr(`T16_ADDR_TMC, 8'h0C);
            wait_req(1'b0, n);
            wait_req(1'b0, n);
            chk("interval", 16'(n), 16'(4 * fac_tab[i]));
            wait_req(1'b1, n);
            chk("second match", 16'(n), 16'(3 * fac_tab[i]));
        end
        wr(`T16_ADDR_TMC, 8'h00);
        rd16(`T16_ADDR_CNT_L, v);
        chk("stopped count", v, 16'h0000);
        $display("test interval done");
        for (i = 5; i < 8; i++) begin
            wr(`T16_ADDR_CCS, 8'(i));
            wr(`T16_ADDR_CCS, 8'(i) | 8'h80);
            toggles(n);
            chk("clock out", 16'(n), 16'(16 >> (i - 5)));
        end
        wr(`T16_ADDR_CCS, 8'h00);
        wr(`T16_ADDR_CCS, 8'h80);
        toggles(n);
        chk("subclock out", {15'h0000, n != 0}, 16'h0001);
        wr(`T16_ADDR_CCS, 8'h81);
        toggles(n);
        chk("prohibited out", 16'(n) | {15'h0000, cout}, 16'h0000);
        $display("test clock output done");
        wr(`T16_ADDR_CCS, 8'h00);
        wr(`T16_ADDR_ESEL, 8'h01);
        wr(`T16_ADDR_TMC, 8'h04);
        repeat (5) i_t16_pins.ev_pulse();
        rd16(`T16_ADDR_CNT_L, v);
        chk("event count", v, 16'h0005);
        wr(`T16_ADDR_TMC, 8'h00);
        wr(`T16_ADDR_CCS, 8'h20);
        wr(`T16_ADDR_TOC, 8'h01);
        wr16(`T16_ADDR_CMP0_L, 16'hFFFF);
        wr16(`T16_ADDR_CMP1_L, 16'hFFFF);
        wr(`T16_ADDR_TMC, 8'h0A);
        repeat (600) @(posedge mclk);
        rd(`T16_ADDR_CNT_H, v);
        chk("count running", v, 16'h0002);
        p = tout;
        i_t16_pins.ev_pulse();
        rd(`T16_ADDR_CNT_H, v);
        chk("cleared by edge", v, 16'h0000);
        chk("pin on edge", {15'h0000, tout}, {15'h0000, ~p});
        $display("test external edge done");
        wr(`T16_ADDR_TMC, 8'h00);
        wr(`T16_ADDR_TMC, 8'h02);
        wr16(`T16_ADDR_CMP0_L, 16'h0040);
        repeat (4) @(posedge mclk);
        chk("pwm active", {15'h0000, tout}, 16'h0001);
        repeat (80) @(posedge mclk);
        chk("pwm idle", {15'h0000, tout}, 16'h0000);
        $display("test pwm done");
        wr(`T16_ADDR_TMC, 8'h00);
        wr16(`T16_ADDR_CMP0_L, 16'hFFFF);
        wr(`T16_ADDR_TMC, 8'h0C);
        rd(`T16_ADDR_TMC, v);
        chk("no overflow", v, 16'h000C);
        repeat (65600) @(posedge mclk);
        rd(`T16_ADDR_TMC, v);
        chk("overflow", v, 16'h000D);
        wr(`T16_ADDR_TMC, 8'h0C);
        rd(`T16_ADDR_TMC, v);
        chk("overflow cleared", v, 16'h000C);
        $display("test overflow done");
        // latch reset, inversion and the one-shot trigger while running
        wr(`T16_ADDR_TMC, 8'h00);
        wr(`T16_ADDR_TOC, 8'h08);
        wr(`T16_ADDR_TOC, 8'h03);
        wr(`T16_ADDR_TMC, 8'h04);
        repeat (4) @(posedge mclk);
        chk("inverted latch", {15'h0000, tout}, 16'h0001);
        wr(`T16_ADDR_TOC, 8'h13);
        rd(`T16_ADDR_TOC, v);
        chk("trigger reads zero", v, 16'h0003);
        chk("trigger toggles", {15'h0000, tout}, 16'h0000);
        $display("test output latch done");
        // second compare captures on both edges, five cycles apart
        wr(`T16_ADDR_TMC, 8'h00);
        wr(`T16_ADDR_CCC, 8'h02);
        wr(`T16_ADDR_ESEL, 8'h02);
        wr(`T16_ADDR_TMC, 8'h08);
        i_t16_pins.ev_pulse();
        rd16(`T16_ADDR_CMP1_L, v);
        chk("capture width", v, 16'h0004);
        $display("test capture done");
        end_sim;
    end
endmodule
